// ---- design/mcs_top.sv ----
// Motion command sequencer: run, inching, test keys and teaching.
// Assumes command pins asynchronous to REF_CLK and a single AHB-Lite master.
`timescale 1ns/100ps
module mcs_top #(
   parameter int TICK_DIV = mcs_pkg::TICK_CYC,
   parameter int HOLD_TICKS = mcs_pkg::HOLD_MS
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic DATA_SELECT_BIT0,
   input wire logic DATA_SELECT_BIT1,
   input wire logic DATA_SELECT_BIT2,
   input wire logic DATA_SELECT_BIT3,
   input wire logic FORWARD_RUN_INPUT,
   input wire logic REVERSE_RUN_INPUT,
   input wire logic POSITIVE_INCH_INPUT,
   input wire logic NEGATIVE_INCH_INPUT,
   input wire logic FREE_INPUT,
   input wire logic STOP_INPUT,
   output logic READY_OUTPUT,
   output logic MOVE_OUTPUT,
   output logic STEP_PULSE,
   output logic STEP_DIR,
   output logic [7:0] TORQUE_LIMIT,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   // ==========================================================
   // Helpers
   function automatic logic [31:0] sat(input logic [31:0] v, input logic [31:0] hi);
      sat = (v > hi) ? hi : v;
   endfunction : sat

   // ==========================================================
   // Pin synchronisers
   mcs_pkg::mcs_pins_s pin_raw, pin_meta, pin, pin_d;
   assign pin_raw = '{forward_run_input: FORWARD_RUN_INPUT, reverse_run_input: REVERSE_RUN_INPUT,
      pinch: POSITIVE_INCH_INPUT, ninch: NEGATIVE_INCH_INPUT, free: FREE_INPUT,
      stop: STOP_INPUT, sel: {DATA_SELECT_BIT3, DATA_SELECT_BIT2,
      DATA_SELECT_BIT1, DATA_SELECT_BIT0}};
   always_ff @(posedge REF_CLK)
   begin
      pin_meta <= pin_raw;
      pin <= pin_meta;
      pin_d <= pin;
   end
   logic inhibit;
   assign inhibit = pin.free | pin.stop;

   // ==========================================================
   // Registers
   logic [11:0] ent_spd [16];
   logic [14:0] ent_acc [16];
   logic [14:0] ent_dec [16];
   logic [23:0] ent_pos [16];
   logic ent_abs [16];
   logic [22:0] inch_dist;
   logic [11:0] inch_spd;
   logic [14:0] inch_acc;
   logic [7:0] inch_trq;
   logic [23:0] preset_pos;
   logic [1:0] keys;
   logic [1:0] keys_d;
   logic coord_set;
   logic teach_refused;
   logic [23:0] position;
   logic [11:0] cur;
   logic dir;
   mcs_pkg::mcs_state_e state, next_state;

   // ==========================================================
   // AHB-Lite slave: writes zero wait, reads one wait state
   logic wr_pend;
   logic [11:0] wr_addr;
   logic rd_pend;
   logic [11:0] rd_addr;
   logic addr_ok;
   assign addr_ok = HSEL & HTRANS[1] & HREADY;
   logic wr_now;
   assign wr_now = wr_pend;
   logic [31:0] wd;
   assign wd = HWDATA;
   logic [3:0] widx;
   assign widx = wr_addr[7:4];
   logic tbl_wr;
   assign tbl_wr = wr_now & (wr_addr[11:8] == mcs_pkg::OFF_TABLE[11:8]);

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= 12'h000;
         rd_addr <= 12'h000;
         HREADYOUT <= 1'b1;
         HRDATA <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= addr_ok & HWRITE;
         rd_pend <= addr_ok & ~HWRITE;
         if (addr_ok)
         begin
            wr_addr <= HADDR[11:0];
            rd_addr <= HADDR[11:0];
         end
         HREADYOUT <= ~(addr_ok & ~HWRITE);
         if (rd_pend)
            HRDATA <= rd_mux(rd_addr);
      end
   end
   always_ff @(posedge REF_CLK)
      HRESP <= 1'b0;

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      logic [3:0] i;
      i = a[7:4];
      rd_mux = 32'h0000_0000;
      if (a[11:8] == mcs_pkg::OFF_TABLE[11:8])
         unique case (a[3:0])
            4'h0: rd_mux = {20'h0_0000, ent_spd[i]};
            4'h4: rd_mux = {17'h0_0000, ent_acc[i]};
            4'h8: rd_mux = {17'h0_0000, ent_dec[i]};
            4'hc: rd_mux = {7'h00, ent_abs[i], ent_pos[i]};
            default: rd_mux = 32'h0000_0000;
         endcase
      else
         unique case (a)
            mcs_pkg::OFF_CTRL: rd_mux = {30'h0000_0000, keys};
            mcs_pkg::OFF_STAT: rd_mux = {4'h0, cur, 8'h00, 1'b0, state,
               teach_refused, coord_set, MOVE_OUTPUT, READY_OUTPUT};
            mcs_pkg::OFF_POS: rd_mux = {8'h00, position};
            mcs_pkg::OFF_PRESET: rd_mux = {8'h00, preset_pos};
            mcs_pkg::OFF_IDIST: rd_mux = {9'h000, inch_dist};
            mcs_pkg::OFF_ISPD: rd_mux = {20'h0_0000, inch_spd};
            mcs_pkg::OFF_IACC: rd_mux = {17'h0_0000, inch_acc};
            mcs_pkg::OFF_ITRQ: rd_mux = {24'h00_0000, inch_trq};
            default: rd_mux = 32'h0000_0000;
         endcase
   endfunction : rd_mux

   // Inch speed, time and torque clamped to their ranges on write; distance takes the low 23 bits, zero as 1
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         inch_dist <= mcs_pkg::DIST_RST;
         inch_spd <= mcs_pkg::ISPD_RST;
         inch_acc <= mcs_pkg::TIME_RST;
         inch_trq <= mcs_pkg::TRQ_RST;
         preset_pos <= 24'h00_0000;
         keys <= 2'b00;
      end
      else if (wr_now)
         unique case (wr_addr)
            mcs_pkg::OFF_IDIST: inch_dist <= (wd[22:0] == 23'h00_0000) ?
               mcs_pkg::DIST_RST : wd[22:0];
            mcs_pkg::OFF_ISPD: inch_spd <= 12'(sat(wd, 32'(mcs_pkg::SPD_MAX)));
            mcs_pkg::OFF_IACC: inch_acc <= 15'(sat(wd, 32'(mcs_pkg::TIME_MAX)));
            mcs_pkg::OFF_ITRQ: inch_trq <= 8'(sat(wd, 32'(mcs_pkg::TRQ_MAX)));
            mcs_pkg::OFF_PRESET: preset_pos <= wd[23:0];
            mcs_pkg::OFF_CTRL: keys <= {wd[mcs_pkg::CTRL_KEY_DN], wd[mcs_pkg::CTRL_KEY_UP]};
            default: keys <= keys;
         endcase
   end

   // Operation data table; teaching shares the position write port
   logic teach_wr;
   assign teach_wr = wr_now & (wr_addr == mcs_pkg::OFF_TEACH);
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         for (int k = 0; k < 16; k++)
         begin
            ent_spd[k] <= mcs_pkg::ESPD_RST;
            ent_acc[k] <= mcs_pkg::TIME_RST;
            ent_dec[k] <= mcs_pkg::TIME_RST;
            ent_pos[k] <= 24'h00_0000;
            ent_abs[k] <= 1'b0;
         end
         teach_refused <= 1'b0;
      end
      else if (teach_wr)
      begin
         teach_refused <= inhibit;
         if (!inhibit)
         begin
            ent_pos[wd[3:0]] <= position;
            ent_abs[wd[3:0]] <= 1'b1;
         end
      end
      else if (tbl_wr)
         unique case (wr_addr[3:0])
            4'h0: ent_spd[widx] <= 12'(sat(wd, 32'(mcs_pkg::SPD_MAX)));
            4'h4: ent_acc[widx] <= 15'(sat(wd, 32'(mcs_pkg::TIME_MAX)));
            4'h8: ent_dec[widx] <= 15'(sat(wd, 32'(mcs_pkg::TIME_MAX)));
            4'hc:
            begin
               ent_pos[widx] <= wd[23:0];
               ent_abs[widx] <= wd[mcs_pkg::ABS_BIT];
            end
            default: ent_abs[widx] <= ent_abs[widx];
         endcase
   end

   // ==========================================================
   // Millisecond enable and hold timer
   logic [31:0] div_cnt;
   logic ms_tick;
   logic [31:0] hold_cnt;
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST || div_cnt == 32'(TICK_DIV - 1))
         div_cnt <= 32'h0000_0000;
      else
         div_cnt <= div_cnt + 32'h0000_0001;
      ms_tick <= !SYS_RST && div_cnt == 32'(TICK_DIV - 1);
   end
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST || state != mcs_pkg::S_THOLD)
         hold_cnt <= 32'h0000_0000;
      else if (ms_tick)
         hold_cnt <= hold_cnt + 32'h0000_0001;
   end

   // ==========================================================
   // Sequencer
   logic [22:0] remain;
   logic step;
   logic inch_done;
   logic key_held;
   logic key_rise;
   logic act_run;
   logic test_inch;
   logic opp_run;
   assign key_held = dir ? keys[0] : keys[1];
   assign key_rise = |(keys & ~keys_d);
   assign inch_done = (state == mcs_pkg::S_INCH) && step && remain == 23'h00_0001;
   assign act_run = dir ? pin.forward_run_input : pin.reverse_run_input;
   assign opp_run = dir ? (pin.reverse_run_input & ~pin.forward_run_input) : (pin.forward_run_input & ~pin.reverse_run_input);

   always_comb
   begin
      next_state = state;
      unique case (state)
         mcs_pkg::S_IDLE:
            if (pin.forward_run_input || pin.reverse_run_input)
               next_state = (pin.forward_run_input && pin.reverse_run_input) ? mcs_pkg::S_BOTH : mcs_pkg::S_RUN;
            else if (key_rise && !inhibit)
               next_state = mcs_pkg::S_INCH;
            else if (!inhibit && ((pin.pinch && !pin_d.pinch) || (pin.ninch && !pin_d.ninch)))
               next_state = mcs_pkg::S_INCH;
         mcs_pkg::S_RUN:
            if (pin.forward_run_input && pin.reverse_run_input)
               next_state = mcs_pkg::S_BOTH;
            else if (!act_run)
               next_state = mcs_pkg::S_DECEL;
         mcs_pkg::S_DECEL:
            if (pin.forward_run_input && pin.reverse_run_input)
               next_state = mcs_pkg::S_BOTH;
            else if (act_run)
               next_state = mcs_pkg::S_RUN;
            else if (cur == 12'h000)
               next_state = opp_run ? mcs_pkg::S_RUN : mcs_pkg::S_IDLE;
         mcs_pkg::S_BOTH:
            if (cur == 12'h000 && !pin.forward_run_input && !pin.reverse_run_input)
               next_state = mcs_pkg::S_IDLE;
         mcs_pkg::S_INCH:
            if (inch_done)
               next_state = (key_held && test_inch) ? mcs_pkg::S_THOLD :
                  mcs_pkg::S_IDLE;
         mcs_pkg::S_THOLD:
            if (!key_held)
               next_state = mcs_pkg::S_IDLE;
            else if (hold_cnt >= 32'(HOLD_TICKS))
               next_state = mcs_pkg::S_TRUN;
         mcs_pkg::S_TRUN:
            if (!key_held && cur == 12'h000)
               next_state = mcs_pkg::S_IDLE;
         default: next_state = mcs_pkg::S_IDLE;
      endcase
   end

   // State, direction and inch distance
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         state <= mcs_pkg::S_IDLE;
         dir <= 1'b1;
         remain <= 23'h00_0000;
         keys_d <= 2'b00;
         test_inch <= 1'b0;
      end
      else
      begin
         state <= next_state;
         keys_d <= keys;
         if (state == mcs_pkg::S_IDLE && next_state == mcs_pkg::S_RUN)
            dir <= pin.forward_run_input;
         else if (state == mcs_pkg::S_DECEL && next_state == mcs_pkg::S_RUN && !act_run)
            dir <= ~dir;
         else if (state == mcs_pkg::S_IDLE && next_state == mcs_pkg::S_INCH)
         begin
            test_inch <= key_rise;
            dir <= key_rise ? keys[0] : (pin.pinch && !pin_d.pinch);
            remain <= key_rise ? 23'h00_0001 : inch_dist;
         end
         else if (state == mcs_pkg::S_INCH && step)
            remain <= remain - 23'h00_0001;
      end
   end

   // ==========================================================
   // Speed ramp: one r/min per step once enough time has built up
   logic [11:0] tgt;
   logic [14:0] rtime;
   logic [19:0] racc;
   always_comb
   begin
      tgt = 12'h000;
      rtime = inch_acc;
      unique case (state)
         mcs_pkg::S_RUN: tgt = ent_spd[pin.sel];
         mcs_pkg::S_INCH: tgt = inch_spd;
         mcs_pkg::S_TRUN: tgt = key_held ? inch_spd : 12'h000;
         default: tgt = 12'h000;
      endcase
      if (state == mcs_pkg::S_RUN || state == mcs_pkg::S_DECEL || state == mcs_pkg::S_BOTH)
         rtime = (cur < tgt) ? ent_acc[pin.sel] : ent_dec[pin.sel];
   end
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST || inch_done)
      begin
         cur <= 12'h000;
         racc <= 20'h0_0000;
      end
      else if (cur == tgt)
         racc <= 20'h0_0000;
      else if (ms_tick)
         racc <= racc[19] ? racc : racc + 20'(mcs_pkg::RATED_RPM);
      else if (racc >= 20'(rtime))
      begin
         racc <= racc - 20'(rtime);
         cur <= (cur < tgt) ? cur + 12'h001 : cur - 12'h001;
      end
   end

   // ==========================================================
   // Step generator: 500 steps per revolution
   logic [23:0] phase;
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST || cur == 12'h000)
      begin
         phase <= 24'h00_0000;
         step <= 1'b0;
      end
      else if (phase + 24'(cur) >= 24'(mcs_pkg::STEP_THRESH))
      begin
         phase <= phase + 24'(cur) - 24'(mcs_pkg::STEP_THRESH);
         step <= 1'b1;
      end
      else
      begin
         phase <= phase + 24'(cur);
         step <= 1'b0;
      end
   end

   // Position counter and coordinate flag
   logic preset_wr;
   assign preset_wr = wr_now && wr_addr == mcs_pkg::OFF_CTRL && state == mcs_pkg::S_IDLE;
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         position <= 24'h00_0000;
         coord_set <= 1'b0;
      end
      else if (preset_wr && (wd[mcs_pkg::CTRL_PRESET] || wd[mcs_pkg::CTRL_HOMED]))
      begin
         position <= wd[mcs_pkg::CTRL_PRESET] ? preset_pos : 24'h00_0000;
         coord_set <= 1'b1;
      end
      else if (step)
         position <= dir ? position + 24'h00_0001 : position - 24'h00_0001;
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         READY_OUTPUT <= 1'b0;
         MOVE_OUTPUT <= 1'b0;
         STEP_PULSE <= 1'b0;
         STEP_DIR <= 1'b1;
         TORQUE_LIMIT <= mcs_pkg::TRQ_RST;
      end
      else
      begin
         READY_OUTPUT <= next_state == mcs_pkg::S_IDLE;
         MOVE_OUTPUT <= cur != 12'h000 || next_state == mcs_pkg::S_RUN ||
            next_state == mcs_pkg::S_INCH || next_state == mcs_pkg::S_TRUN;
         STEP_PULSE <= step;
         STEP_DIR <= dir;
         TORQUE_LIMIT <= (state == mcs_pkg::S_INCH || state == mcs_pkg::S_TRUN) ?
            inch_trq : mcs_pkg::TRQ_RST;
      end
   end

   // ==========================================================
   // Checks
   run_ready_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state == mcs_pkg::S_RUN |=> !READY_OUTPUT)
      else $error("ready high while running");
   both_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state == mcs_pkg::S_BOTH && (pin.forward_run_input || pin.reverse_run_input) |=> !READY_OUTPUT)
      else $error("ready rose before both run inputs released");
   both_move_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state == mcs_pkg::S_BOTH && cur == 12'h000 |=> !MOVE_OUTPUT)
      else $error("motion still high after both-input stop");
   inch_block_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state == mcs_pkg::S_IDLE && inhibit |=> state != mcs_pkg::S_INCH)
      else $error("inch started while inhibited");
   teach_refuse_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      teach_wr |=> teach_refused == $past(inhibit))
      else $error("teach refusal flag wrong");
   step_count_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      step && !preset_wr && dir |=> position == $past(position) + 24'h00_0001)
      else $error("position did not follow step");
   speed_max_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      cur <= mcs_pkg::SPD_MAX && inch_dist != 23'h00_0000)
      else $error("speed or inch distance out of range");
   inch_end_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      inch_done |=> cur == 12'h000 ##1 (READY_OUTPUT || state == mcs_pkg::S_THOLD))
      else $error("inch completion did not stop and raise ready");
endmodule : mcs_top

// ---- inc/mcs_pkg.sv ----
// Constants, register map and carrier types of the motion command sequencer.
// Assumes one 50 MHz clock and a word-aligned AHB-Lite register window.
package mcs_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int HOLD_MS = 500;
   localparam int STEPS_PER_REV = 500;
   localparam int STEP_THRESH = CLK_HZ / STEPS_PER_REV * 60;
   localparam logic [11:0] RATED_RPM = 12'h0bb8;
   // ==========================================================
   // Limits and reset values
   localparam logic [11:0] SPD_MAX = 12'h0fa0;
   localparam logic [14:0] TIME_MAX = 15'h7530;
   localparam logic [7:0] TRQ_MAX = 8'h00fa;
   localparam logic [22:0] DIST_MAX = 23'h7f_ffff;
   localparam logic [22:0] DIST_RST = 23'h00_0001;
   localparam logic [11:0] ISPD_RST = 12'h012c;
   localparam logic [14:0] TIME_RST = 15'h0064;
   localparam logic [7:0] TRQ_RST = 8'h0064;
   localparam logic [11:0] ESPD_RST = 12'h0000;
   // ==========================================================
   // Register offsets
   localparam logic [11:0] OFF_CTRL = 12'h0000;
   localparam logic [11:0] OFF_STAT = 12'h0004;
   localparam logic [11:0] OFF_POS = 12'h0008;
   localparam logic [11:0] OFF_PRESET = 12'h000c;
   localparam logic [11:0] OFF_IDIST = 12'h0010;
   localparam logic [11:0] OFF_ISPD = 12'h0014;
   localparam logic [11:0] OFF_IACC = 12'h0018;
   localparam logic [11:0] OFF_ITRQ = 12'h001c;
   localparam logic [11:0] OFF_TEACH = 12'h0020;
   localparam logic [11:0] OFF_TABLE = 12'h0100;
   // Control bits and the table entry absolute bit
   localparam int CTRL_KEY_UP = 0;
   localparam int CTRL_KEY_DN = 1;
   localparam int CTRL_PRESET = 8;
   localparam int CTRL_HOMED = 9;
   localparam int ABS_BIT = 24;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RUN = 3'b001,
      S_DECEL = 3'b010,
      S_BOTH = 3'b011,
      S_INCH = 3'b100,
      S_THOLD = 3'b101,
      S_TRUN = 3'b110
   } mcs_state_e;

   typedef struct packed {
      logic forward_run_input;
      logic reverse_run_input;
      logic pinch;
      logic ninch;
      logic free;
      logic stop;
      logic [3:0] sel;
   } mcs_pins_s;
endpackage : mcs_pkg

// ---- testbench/mcs_host.sv ----
// Host model driving the command pins of the sequencer.
// Assumes the bench clock and the ready output of the device.
`timescale 1ns/100ps
module mcs_host (
   input wire logic clk,
   input wire logic ready,
   output mcs_pkg::mcs_pins_s pins
);
   // ==========================================
   // Pin drivers
   initial pins = '0;
   task automatic set(input logic f, input logic r, input logic fr, input logic st);
      @(posedge clk);
      pins.forward_run_input <= f;
      pins.reverse_run_input <= r;
      pins.free <= fr;
      pins.stop <= st;
   endtask : set
   // 100 cycles is 10 ms at the shortened tick
   task automatic run(input logic [3:0] n, input logic f, input logic r);
      @(posedge clk);
      pins.sel <= n;
      repeat (100) @(posedge clk);
      pins.forward_run_input <= f;
      pins.reverse_run_input <= r;
   endtask : run
   // Releases only after ready drops, or gives up
   task automatic inch(input logic pos);
      for (int k = 0; k < 50 && ready !== 1'b1; k++)
         @(negedge clk);
      @(posedge clk);
      pins.pinch <= pos;
      pins.ninch <= !pos;
      for (int k = 0; k < 20 && ready !== 1'b0; k++)
         @(negedge clk);
      @(posedge clk);
      pins.pinch <= 1'b0;
      pins.ninch <= 1'b0;
   endtask : inch
endmodule : mcs_host

// ---- testbench/mcs_top_bench.sv ----
// Self-checking bench of the sequencer: registers, runs, inching, teaching.
// Assumes the host model drives the pins and this bench is the bus master.
`timescale 1ns/100ps
module mcs_top_bench;
   logic clk = 0, rst = 1, rdy, mov, stp, dir, ho, hr, hs = 0, hw = 0;
   logic [7:0] trq;
   logic [31:0] hrd, ha = '0, hwd = '0, q, v;
   logic [1:0] ht = '0;
   logic [2:0] hz = '0;
   logic [3:0] n;
   mcs_pkg::mcs_pins_s p;
   int n_errors = 0, checked = 0, steps = 0;
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (stp === 1'b1) steps <= steps + (dir ? 1 : -1);
   mcs_host mcs_host_inst (.clk(clk), .ready(rdy), .pins(p));
   mcs_top #(.TICK_DIV(10), .HOLD_TICKS(3)) mcs_top_inst (.REF_CLK(clk), .SYS_RST(rst),
      .DATA_SELECT_BIT0(p.sel[0]), .DATA_SELECT_BIT1(p.sel[1]),
      .DATA_SELECT_BIT2(p.sel[2]), .DATA_SELECT_BIT3(p.sel[3]),
      .FORWARD_RUN_INPUT(p.forward_run_input), .REVERSE_RUN_INPUT(p.reverse_run_input), .POSITIVE_INCH_INPUT(p.pinch),
      .NEGATIVE_INCH_INPUT(p.ninch), .FREE_INPUT(p.free), .STOP_INPUT(p.stop),
      .READY_OUTPUT(rdy), .MOVE_OUTPUT(mov), .STEP_PULSE(stp), .STEP_DIR(dir),
      .TORQUE_LIMIT(trq), .HSEL(hs), .HADDR(ha), .HTRANS(ht), .HWRITE(hw), .HSIZE(hz),
      .HWDATA(hwd), .HREADY(ho), .HRDATA(hrd), .HREADYOUT(ho), .HRESP(hr));
   // ==========================================
   // Checks and bus cycles
   task automatic close_out(input logic hang);
      if (hang)
         n_errors++;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Ready is sampled half a cycle early so no edge race decides it
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic r;
      hs <= 1'b1;
      ht <= 2'b10;
      hw <= w;
      hz <= 3'h2;
      ha <= {20'h0_0000, a};
      for (int ph = 0; ph < 2; ph++)
      begin
         r = 1'b0;
         for (int k = 0; k < 40 && r !== 1'b1; k++)
         begin
            @(negedge clk);
            r = ho;
            q = hrd;
            @(posedge clk);
         end
         if (r !== 1'b1)
            close_out(1'b1);
         // Data phase once only, so a following call never rewrites ht in one step
         if (ph == 0)
         begin
            ht <= 2'b00;
            hwd <= d;
         end
      end
   endtask : bus
   task automatic wait_pins(input logic rv, input logic mv);
      for (int k = 0; k < 45000 && {rdy, mov} !== {rv, mv}; k++)
         @(negedge clk);
      chk({30'h0, rdy, mov}, {30'h0, rv, mv});
      if ({rdy, mov} !== {rv, mv})
         close_out(1'b1);
   endtask : wait_pins
   // ==========================================
   // Scenarios
   logic [11:0] offs [4] = '{12'h010, 12'h014, 12'h018, 12'h01c};
   logic [31:0] rsts [4] = '{32'h1, 32'h12c, 32'h64, 32'h64};
   logic [31:0] maxs [4] = '{32'h7f_ffff, 32'hfa0, 32'h7530, 32'hfa};
   initial
   begin
      void'($urandom(7));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         bus(0, offs[i], 0);
         chk(q, rsts[i]);
         bus(1, offs[i], 32'hffff_ffff);
         bus(0, offs[i], 0);
         chk(q, maxs[i]);
         bus(1, offs[i], rsts[i]);
      end
      bus(1, offs[0], 0);
      bus(0, offs[0], 0);
      chk(q, 32'h1);
      bus(0, 12'hff0, 0);
      chk(q, 32'h0);
      chk({31'h0, hr}, 32'h0);
      chk({24'h0, trq}, 32'h64);
      $display("test registers done");
      n = 4'($urandom_range(15, 1));
      bus(1, 12'h100 + 12'(n) * 12'h010, 32'h5);
      bus(1, 12'h108 + 12'(n) * 12'h010, 32'h7530);
      mcs_host_inst.run(n, 1'b1, 1'b0);
      wait_pins(1'b0, 1'b1);
      repeat (300) @(posedge clk);
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({20'h0, q[27:16]}, 32'h5);
      mcs_host_inst.set(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (50) @(posedge clk);
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({29'h0, q[6:4]}, 32'h2);
      mcs_host_inst.set(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge clk);
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({29'h0, q[6:4]}, 32'h1);
      mcs_host_inst.set(1'b0, 1'b1, 1'b0, 1'b0);
      repeat (900) @(posedge clk);
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({28'h0, dir, q[6:4]}, 32'h1);
      mcs_host_inst.set(1'b1, 1'b1, 1'b0, 1'b0);
      wait_pins(1'b0, 1'b0);
      mcs_host_inst.set(1'b0, 1'b0, 1'b0, 1'b0);
      wait_pins(1'b1, 1'b0);
      $display("test run done");
      mcs_host_inst.set(1'b0, 1'b0, 1'b1, 1'b0);
      mcs_host_inst.inch(1'b1);
      repeat (20) @(posedge clk);
      chk(32'(steps), 32'h0);
      chk({31'h0, rdy}, 32'h1);
      mcs_host_inst.set(1'b0, 1'b0, 1'b0, 1'b0);
      v = $urandom_range(250, 1);
      bus(1, mcs_pkg::OFF_ITRQ, v);
      mcs_host_inst.inch(1'b1);
      @(negedge clk);
      chk({24'h0, trq}, v);
      wait_pins(1'b1, 1'b0);
      chk(32'(steps), 32'h1);
      mcs_host_inst.inch(1'b0);
      wait_pins(1'b1, 1'b0);
      chk(32'(steps), 32'h0);
      $display("test inch done");
      q = '0;
      bus(1, mcs_pkg::OFF_CTRL, 32'h0000_0001);
      for (int k = 0; k < 300 && q[6:4] !== 3'h6; k++)
      begin
         repeat (100) @(posedge clk);
         bus(0, mcs_pkg::OFF_STAT, 0);
      end
      chk({29'h0, q[6:4]}, 32'h6);
      if (q[6:4] !== 3'h6)
         close_out(1'b1);
      chk(32'(steps), 32'h1);
      bus(1, mcs_pkg::OFF_CTRL, 32'h0000_0000);
      wait_pins(1'b1, 1'b0);
      chk({31'h0, dir}, 32'h1);
      $display("test keys done");
      v = $urandom & 32'h007f_ffff;
      bus(1, mcs_pkg::OFF_PRESET, v);
      bus(1, mcs_pkg::OFF_CTRL, 32'h0000_0100);
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({31'h0, q[2]}, 32'h1);
      bus(1, mcs_pkg::OFF_TEACH, {28'h0, n});
      bus(0, 12'h10c + 12'(n) * 12'h010, 0);
      chk(q, v | 32'h0100_0000);
      mcs_host_inst.set(1'b0, 1'b0, 1'b0, 1'b1);
      repeat (5) @(posedge clk);
      bus(1, mcs_pkg::OFF_TEACH, {28'h0, n ^ 4'h1});
      bus(0, mcs_pkg::OFF_STAT, 0);
      chk({31'h0, q[3]}, 32'h1);
      bus(0, 12'h10c + 12'(n ^ 4'h1) * 12'h010, 0);
      chk(q, 32'h0);
      $display("test teach done");
      close_out(1'b0);
   end
endmodule : mcs_top_bench
